// >>> see_consts.svh
// Constants for the serial EEPROM command and protection front end
`ifndef SEE_CONSTS_SVH
`define SEE_CONSTS_SVH
`define SEE_OP_MASK 8'hf7
`define SEE_OP_SET_LATCH 8'h06
`define SEE_OP_CLR_LATCH 8'h04
`define SEE_OP_FETCH 8'h05
`define SEE_OP_STORE 8'h01
`define SEE_OP_READ 8'h03
`define SEE_OP_WRITE 8'h02
`define SEE_LEN_OP 5'h08
`define SEE_LEN_SR 5'h10
`define SEE_SR_LAST 5'h0f
`define SEE_ADDR_LAST 5'h17
`define SEE_DATA_FIRST 5'h18
`define SEE_CNT_LAST 5'h1f
`define SEE_BYTE_LAST 3'h7
`define SEE_BUSY_VIEW 8'hff
`define SEE_BP_FACTORY 2'h0
`define SEE_QTR_BASE 11'h600
`define SEE_HALF_BASE 11'h400
`define SEE_T_WRITE_NS 5000000
`define SEE_CLK_NS 10
`endif

// >>> see_pkg.sv
// Types for the serial EEPROM command and protection front end
package see_pkg;
  typedef enum logic [1:0] {
    SEE_IDLE = 2'h0,
    SEE_WRITING = 2'h1,
    SEE_COMMIT = 2'h3
  } see_state_t;
  typedef struct packed {
    logic hw_guard_arm;
    logic [2:0] spare;
    logic block_guard_high;
    logic block_guard_low;
    logic write_latch;
    logic busy;
  } see_status_t;
  typedef struct packed {
    logic [7:0] op;
    logic [7:0] data;
    logic [4:0] len;
  } see_frame_t;
endpackage

// >>> see_eeprom_front.sv
// SPI slave front end: instruction decode, status and write protection
// ==========================================
`timescale 1ns/1ps
`include "see_consts.svh"

module see_eeprom_front import see_pkg::*; #(
  parameter int WRITE_CYCLES = `SEE_T_WRITE_NS / `SEE_CLK_NS
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic sck_in,
  input wire logic cs_n_in,
  input wire logic si_in,
  input wire logic wp_n_in,
  output logic so_out,
  output logic so_oe_out
);

  // ==========================================
  // Shared helpers
  function automatic logic is_locked(input logic [10:0] a, input logic [1:0] bp);
    case (bp)
      2'h1: is_locked = a >= `SEE_QTR_BASE;
      2'h2: is_locked = a >= `SEE_HALF_BASE;
      2'h3: is_locked = 1'b1;
      default: is_locked = 1'b0;
    endcase
  endfunction

  function automatic logic [7:0] op_code(input logic [7:0] op);
    op_code = op & `SEE_OP_MASK;
  endfunction

  logic [7:0] mem [0:2047];
  logic [7:0] pg [0:31];

  // ==========================================
  // Link side, rising clock
  logic [4:0] cnt_q, cnt_d;
  logic [7:0] op_q, op_d;
  logic [7:0] dat_q, dat_d;
  logic [10:0] adr_q, adr_d;
  logic [31:0] msk_q, msk_d;
  logic [4:0] len_q;
  logic [7:0] sr_m_q, sr_s_q;
  logic [7:0] stat_q;
  logic [7:0] code;
  logic byte_end;
  logic pg_we;

  always_comb begin
    code = op_code(op_q);
    byte_end = (cnt_q >= `SEE_ADDR_LAST) && (cnt_q[2:0] == `SEE_BYTE_LAST);
    op_d = op_q;
    dat_d = {dat_q[6:0], si_in};
    adr_d = adr_q;
    msk_d = msk_q;
    pg_we = 1'b0;
    if (cnt_q < `SEE_LEN_OP) begin
      op_d = {op_q[6:0], si_in};
    end
    if (cnt_q == 5'h00) begin
      msk_d = 32'h0;
    end
    if ((cnt_q >= `SEE_LEN_OP) && (cnt_q <= `SEE_ADDR_LAST)) begin
      adr_d = {adr_q[9:0], si_in};
    end else if (byte_end && cnt_q != `SEE_ADDR_LAST) begin
      if (code == `SEE_OP_READ) begin
        adr_d = adr_q + 11'h001;
      end else if (code == `SEE_OP_WRITE && !sr_s_q[0]) begin
        pg_we = 1'b1;
        msk_d = msk_q | (32'h1 << adr_q[4:0]);
        adr_d = {adr_q[10:5], adr_q[4:0] + 5'h01};
      end
    end
    if (code == `SEE_OP_FETCH && cnt_q == `SEE_SR_LAST) begin
      cnt_d = `SEE_LEN_OP;
    end else if ((code == `SEE_OP_READ || code == `SEE_OP_WRITE) &&
                 cnt_q == `SEE_CNT_LAST && cnt_q >= `SEE_LEN_OP) begin
      cnt_d = `SEE_DATA_FIRST;
    end else if (cnt_q == `SEE_CNT_LAST) begin
      cnt_d = cnt_q;
    end else begin
      cnt_d = cnt_q + 5'h01;
    end
  end

  always_ff @(posedge sck_in or posedge cs_n_in or negedge rstn_in) begin
    if (!rstn_in || cs_n_in) begin
      cnt_q <= 5'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge sck_in or negedge rstn_in) begin
    if (!rstn_in) begin
      op_q <= 8'h00;
      dat_q <= 8'h00;
      adr_q <= 11'h000;
      msk_q <= 32'h0;
      len_q <= 5'h00;
      sr_m_q <= `SEE_BUSY_VIEW;
      sr_s_q <= `SEE_BUSY_VIEW;
    end else begin
      op_q <= op_d;
      dat_q <= dat_d;
      adr_q <= adr_d;
      msk_q <= msk_d;
      len_q <= cnt_d;
      sr_m_q <= stat_q;
      sr_s_q <= sr_m_q;
    end
  end

  always_ff @(posedge sck_in) begin
    if (pg_we) begin
      pg[adr_q[4:0]] <= {dat_q[6:0], si_in};
    end
  end

  // ==========================================
  // Link side, falling clock output
  logic so_d, oe_d;
  logic [7:0] rd_byte;
  logic so_q, oe_q;

  always_comb begin
    rd_byte = mem[adr_q];
    oe_d = 1'b0;
    so_d = 1'b0;
    if (code == `SEE_OP_FETCH && cnt_q >= `SEE_LEN_OP) begin
      oe_d = 1'b1;
      so_d = sr_s_q[~cnt_q[2:0]];
    end else if (code == `SEE_OP_READ && cnt_q >= `SEE_DATA_FIRST && !sr_s_q[0]) begin
      oe_d = 1'b1;
      so_d = rd_byte[~cnt_q[2:0]];
    end
  end

  always_ff @(negedge sck_in or posedge cs_n_in or negedge rstn_in) begin
    if (!rstn_in || cs_n_in) begin
      so_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      so_q <= so_d;
      oe_q <= oe_d;
    end
  end

  assign so_out = so_q;
  assign so_oe_out = oe_q;

  // ==========================================
  // System side synchronisers
  logic cs1_q, cs2_q, cs3_q, wp1_q, wp2_q;
  logic end_ev;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cs1_q <= 1'b1;
      cs2_q <= 1'b1;
      cs3_q <= 1'b1;
      wp1_q <= 1'b1;
      wp2_q <= 1'b1;
    end else begin
      cs1_q <= cs_n_in;
      cs2_q <= cs1_q;
      cs3_q <= cs2_q;
      wp1_q <= wp_n_in;
      wp2_q <= wp1_q;
    end
  end

  assign end_ev = cs2_q && !cs3_q;

  // ==========================================
  // Status and write cycle control
  see_state_t state_q, state_d;
  see_frame_t frm;
  see_status_t stat_d;
  logic wel_q, wel_d;
  logic [1:0] bp_q, bp_d;
  logic arm_q, arm_d;
  logic [19:0] tmr_q, tmr_d;
  logic [7:0] pend_q, pend_d;
  logic kind_q, kind_d;
  logic [5:0] base_q, base_d;
  logic [31:0] wmsk_q, wmsk_d;
  logic hwp;
  logic [7:0] fcode;

  always_comb begin
    frm = '{op: op_q, data: dat_q, len: len_q};
    fcode = op_code(frm.op);
    hwp = arm_q && !wp2_q;
    state_d = state_q;
    wel_d = wel_q;
    bp_d = bp_q;
    arm_d = arm_q;
    tmr_d = tmr_q;
    pend_d = pend_q;
    kind_d = kind_q;
    base_d = base_q;
    wmsk_d = wmsk_q;
    case (state_q)
      SEE_IDLE: begin
        if (end_ev) begin
          if (fcode == `SEE_OP_SET_LATCH && frm.len == `SEE_LEN_OP) begin
            wel_d = 1'b1;
          end else if (fcode == `SEE_OP_CLR_LATCH && frm.len == `SEE_LEN_OP) begin
            wel_d = 1'b0;
          end else if (fcode == `SEE_OP_STORE && frm.len == `SEE_LEN_SR &&
                       wel_q && !hwp) begin
            pend_d = frm.data;
            kind_d = 1'b0;
            wel_d = 1'b0;
            tmr_d = 20'(WRITE_CYCLES - 1);
            state_d = SEE_WRITING;
          end else if (fcode == `SEE_OP_WRITE && frm.len == `SEE_DATA_FIRST &&
                       msk_q != 32'h0 && wel_q) begin
            kind_d = 1'b1;
            base_d = adr_q[10:5];
            wmsk_d = msk_q;
            wel_d = 1'b0;
            tmr_d = 20'(WRITE_CYCLES - 1);
            state_d = SEE_WRITING;
          end
        end
      end
      SEE_WRITING: begin
        if (tmr_q == 20'h0) begin
          state_d = SEE_COMMIT;
        end else begin
          tmr_d = tmr_q - 20'h1;
        end
      end
      SEE_COMMIT: begin
        if (!kind_q) begin
          bp_d = pend_q[3:2];
          arm_d = (arm_q && !wp2_q) ? 1'b1 : pend_q[7];
        end
        state_d = SEE_IDLE;
      end
      default: begin
        state_d = SEE_IDLE;
      end
    endcase
    stat_d = '{hw_guard_arm: arm_d, spare: 3'h0, block_guard_high: bp_d[1],
               block_guard_low: bp_d[0], write_latch: wel_d, busy: 1'b0};
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_q <= SEE_IDLE;
      wel_q <= 1'b0;
      bp_q <= `SEE_BP_FACTORY;
      arm_q <= 1'b0;
      tmr_q <= 20'h0;
      pend_q <= 8'h00;
      kind_q <= 1'b0;
      base_q <= 6'h00;
      wmsk_q <= 32'h0;
      stat_q <= {4'h0, `SEE_BP_FACTORY, 2'h0};
    end else begin
      state_q <= state_d;
      wel_q <= wel_d;
      bp_q <= bp_d;
      arm_q <= arm_d;
      tmr_q <= tmr_d;
      pend_q <= pend_d;
      kind_q <= kind_d;
      base_q <= base_d;
      wmsk_q <= wmsk_d;
      stat_q <= (state_d != SEE_IDLE) ? `SEE_BUSY_VIEW : stat_d;
    end
  end

  // ==========================================
  // Array commit, unlocked bytes only
  always_ff @(posedge clk_in) begin
    if (state_q == SEE_COMMIT && kind_q) begin
      for (int i = 0; i < 32; i++) begin
        if (wmsk_q[i] && !is_locked({base_q, 5'(i)}, bp_q)) begin
          mem[{base_q, 5'(i)}] <= pg[i];
        end
      end
    end
  end

  // ==========================================
  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  a_busy_all_ones: assert property ((state_q != SEE_IDLE) |-> stat_q == `SEE_BUSY_VIEW)
    else $error("status not all ones while busy");
  a_idle_spare_zero: assert property ((state_q == SEE_IDLE) |->
    stat_q[6:4] == 3'h0 && !stat_q[0])
    else $error("spare or busy bit set while idle");
  a_latch_mirror: assert property ((state_q == SEE_IDLE) |-> stat_q[1] == wel_q)
    else $error("latch bit does not mirror latch");
  a_busy_no_change: assert property ((state_q == SEE_WRITING) |=> $stable(wel_q))
    else $error("latch changed during write cycle");
  a_store_needs_latch: assert property ($rose(state_q == SEE_WRITING) |->
    $past(wel_q) && !wel_q)
    else $error("write cycle started without latch");
  a_arm_hold_pin: assert property (arm_q && !wp2_q |=> arm_q)
    else $error("arm bit cleared with pin low");
  a_guard_only_commit: assert property ((state_q != SEE_COMMIT) |=>
    $stable(bp_q) && $stable(arm_q))
    else $error("guard bits changed outside commit");
  a_commit_after_count: assert property ((state_q == SEE_COMMIT) |->
    $past(state_q) == SEE_WRITING && $past(tmr_q) == 20'h0)
    else $error("commit before write time elapsed");
  a_hw_lock_store: assert property (hwp && state_q == SEE_IDLE |=>
    state_q != SEE_WRITING || $past(kind_d))
    else $error("status store taken under hardware guard");
  a_output_released: assert property (cs2_q |-> !so_oe_out)
    else $error("output driven while deselected");

  c_store_commit: cover property (state_q == SEE_COMMIT && !kind_q);
  c_array_commit: cover property (state_q == SEE_COMMIT && kind_q);
  c_latch_set: cover property (end_ev ##1 wel_q);
  c_guard_armed: cover property (hwp && state_q == SEE_IDLE);

endmodule

// >>> see_host_model.sv
// Host SPI master model driving one mode 0 or mode 3 frame at a time
`timescale 1ns/1ps
module see_host_model (
  output logic sck_out,
  output logic cs_n_out,
  output logic si_out,
  input wire logic so_in,
  input wire logic so_oe_in
);
  // ==========================================
  // Frame driver
  logic idle_hi;

  initial begin
    idle_hi = 1'b0;
    sck_out = 1'b0; // Idle low clock selects mode 0
    cs_n_out = 1'b1;
    si_out = 1'b0;
  end

  task automatic xfer(input logic [63:0] tx, input int n, output logic [63:0] rx,
                      output logic oe);
    rx = '0;
    oe = 1'b0;
    #60;
    cs_n_out = 1'b0; // Frame opens with select low
    for (int i = 0; i < n; i++) begin
      if (idle_hi) begin
        sck_out = 1'b0; // Mode 3 falls first in each bit
      end
      si_out = tx[63 - i]; // Any code given, sent first bit high
      #3 sck_out = 1'b1; // Data taken on rising clock
      rx = {rx[62:0], so_in};
      oe = so_oe_in;
      #3;
      if (!idle_hi) begin
        sck_out = 1'b0;
      end
    end
    #2 cs_n_out = 1'b1; // Select rises before any further rising clock
    si_out = ~si_out;
  endtask

  task automatic set_mode(input logic hi);
    #100;
    idle_hi = hi;
    sck_out = hi; // Idle clock level picks mode 0 or 3
  endtask
endmodule

// >>> test_serial_eeprom_command_and_protection.sv
// Self-checking bench for the serial EEPROM front end
`timescale 1ns/1ps
`include "see_consts.svh"
module test_serial_eeprom_command_and_protection;
  // ==========================================
  // Signals and instances
  logic clk_in, rstn_in, wp_n_in, sck, cs_n, si, so, so_oe, oe;
  logic [63:0] rx;
  int errors, checks_done;

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  see_eeprom_front #(.WRITE_CYCLES(60)) u_dut (.clk_in(clk_in), .rstn_in(rstn_in),
    .sck_in(sck), .cs_n_in(cs_n), .si_in(si), .wp_n_in(wp_n_in), .so_out(so),
    .so_oe_out(so_oe));
  see_host_model u_host (.sck_out(sck), .cs_n_out(cs_n), .si_out(si), .so_in(so),
    .so_oe_in(so_oe));

  // ==========================================
  // Helpers
  task chk8(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task cmd(input logic [7:0] op);
    u_host.xfer({op, 56'h0}, 8, rx, oe);
    #100;
  endtask

  task st_is(input string nm, input logic [7:0] exp);
    u_host.xfer({`SEE_OP_FETCH, 56'h0}, 24, rx, oe);
    chk8(nm, exp, rx[15:8]);
  endtask

  task store(input logic [7:0] d);
    u_host.xfer({`SEE_OP_STORE, d, 48'h0}, 16, rx, oe);
  endtask

  task wr(input logic [15:0] a, input logic [7:0] d);
    cmd(`SEE_OP_SET_LATCH);
    u_host.xfer({`SEE_OP_WRITE, a, d, 32'h0}, 32, rx, oe);
    #800;
  endtask

  task rd(input logic [15:0] a, input int nb);
    u_host.xfer({`SEE_OP_READ, a, 40'h0}, 24 + 8 * nb, rx, oe);
  endtask

  task stop_test;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ==========================================
  // Scenarios
  task t_idle;
    chk8("output enable idle", 8'h00, {7'h0, so_oe});
    st_is("status after reset", 8'h00);
    $display("test idle done");
  endtask

  task t_latch;
    cmd(`SEE_OP_SET_LATCH);
    st_is("latch set", 8'h02);
    cmd(`SEE_OP_CLR_LATCH);
    st_is("latch cleared", 8'h00);
    cmd(8'h0e);
    st_is("latch set by alternate code", 8'h02);
    cmd(8'h0c);
    st_is("latch cleared by alternate code", 8'h00);
    u_host.set_mode(1'b1);
    cmd(`SEE_OP_SET_LATCH);
    st_is("latch set in mode 3", 8'h02);
    cmd(`SEE_OP_CLR_LATCH);
    st_is("latch cleared in mode 3", 8'h00);
    u_host.set_mode(1'b0);
    $display("test latch done");
  endtask

  task t_store;
    store(8'hfc);
    #800;
    st_is("store without latch", 8'h00);
    cmd(`SEE_OP_SET_LATCH);
    store(8'hfc);
    st_is("busy view", 8'hff);
    rd(16'h0000, 1);
    chk8("read enable while busy", 8'h00, {7'h0, oe});
    cmd(`SEE_OP_SET_LATCH);
    #800;
    st_is("stored status", 8'h8c);
    chk8("repeated status", 8'h8c, rx[7:0]);
    $display("test store done");
  endtask

  task t_guard;
    @(posedge clk_in) wp_n_in <= 1'b0;
    #50;
    cmd(`SEE_OP_SET_LATCH);
    store(8'h00);
    #800;
    st_is("store under hardware guard", 8'h8e);
    @(posedge clk_in) wp_n_in <= 1'b1;
    #50;
    store(8'h00);
    #800;
    st_is("store with pin high", 8'h00);
    $display("test guard done");
  endtask

  task t_array;
    wr(16'h07ff, 8'ha5);
    wr(16'h0000, 8'h5a);
    wr(16'h05ff, 8'h3c);
    rd(16'hf7ff, 2);
    chk8("read top byte", 8'ha5, rx[15:8]);
    chk8("read wrapped byte", 8'h5a, rx[7:0]);
    cmd(`SEE_OP_SET_LATCH);
    store(8'h04);
    #800;
    wr(16'h07ff, 8'h11);
    wr(16'h05ff, 8'hc3);
    st_is("latch after write", 8'h04);
    rd(16'h07ff, 1);
    chk8("guarded byte kept", 8'ha5, rx[7:0]);
    rd(16'h05ff, 1);
    chk8("open byte written", 8'hc3, rx[7:0]);
    u_host.xfer({`SEE_OP_READ, 16'h07ff, 40'h0}, 28, rx, oe);
    chk8("output enable during read", 8'h01, {7'h0, oe});
    #1;
    chk8("output enable after abort", 8'h00, {7'h0, so_oe});
    $display("test array done");
  endtask

  // ==========================================
  // Main sequence and watchdog
  initial begin
    rstn_in = 1'b0;
    wp_n_in = 1'b1;
    errors = 0;
    checks_done = 0;
    repeat (2) @(posedge clk_in);
    rstn_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    t_idle();
    t_latch();
    t_store();
    t_guard();
    t_array();
    stop_test();
  end

  initial begin
    #200000;
    errors++;
    stop_test();
  end
endmodule
